//--- core/boot_strap_map.svh
// Constants for the boot source strap decoder
`ifndef BOOT_STRAP_MAP_SVH
`define BOOT_STRAP_MAP_SVH

// Boot select code values, selects read as {bit2, bit1, bit0}
`define BOOT_CODE_CARRIER_SATA 3'h0
`define BOOT_CODE_CARRIER_SD 3'h1
`define BOOT_CODE_CARRIER_ESPI 3'h2
`define BOOT_CODE_CARRIER_SPI 3'h3
`define BOOT_CODE_MODULE_NAND 3'h4
`define BOOT_CODE_REMOTE 3'h5
`define BOOT_CODE_MODULE_EMMC 3'h6
`define BOOT_CODE_MODULE_SPI 3'h7
// Reset value of the held code: all selects floating
`define BOOT_CODE_RESET 3'h7
// Settle counter: first value, last value before capture, step
`define SETTLE_START 2'h0
`define SETTLE_LAST 2'h1
`define SETTLE_STEP 2'h1
// Strap vector width and reset value
`define STRAP_WIDTH 8
`define STRAP_RESET 8'h00
// Bit positions inside the strap vector
`define STRAP_SPI_PORT1_SELECT0_STRAP 0
`define STRAP_SPI_PORT0_SELECT1_STRAP 1
`define STRAP_SPI_PORT1_CLOCK_STRAP 2
`define STRAP_UART0_TXD 3
`define STRAP_UART0_RTS 4
`define STRAP_UART2_TXD 5
`define STRAP_UART2_RTS 6
`define STRAP_SPI1_DOUT 7
// Synchroniser reset level: pins idle high through pull-ups
`define SYNC_RESET_HIGH 1'h1
`define SYNC_RESET_LOW 1'h0

`endif

//--- core/boot_strap_pkg.sv
// Types for the boot source strap decoder
package boot_strap_pkg;

    // Decoded boot source
    typedef enum logic [2:0] {
        SRC_CARRIER_SATA,
        SRC_CARRIER_SD,
        SRC_CARRIER_ESPI,
        SRC_CARRIER_SPI,
        SRC_MODULE_NAND,
        SRC_REMOTE,
        SRC_MODULE_EMMC,
        SRC_MODULE_SPI
    } boot_source_t;

    // Sampler sequence
    typedef enum logic [1:0] {
        ST_RESET,
        ST_SETTLE,
        ST_HELD
    } capture_state_t;

endpackage : boot_strap_pkg

//--- core/pin_sync.sv
// Two flip-flop synchroniser for a vector of pin levels
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] stage1; // First stage, read only by second
    logic [WIDTH-1:0] next_stage1; // Next first stage
    logic [WIDTH-1:0] next_sync; // Next second stage

    // Next values: shift the pin level along
    always_comb begin
        next_stage1 = pin_i;
        next_sync = stage1;
    end

    // Both stages reset to the idle level
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            stage1 <= RESET_VALUE;
            sync_o <= RESET_VALUE;
        end else begin
            stage1 <= next_stage1;
            sync_o <= next_sync;
        end
    end

endmodule : pin_sync

`default_nettype wire

//--- core/boot_source_strap_decoder.sv
// Boot select and configuration strap sampler and decoder
`timescale 1ns/1ns
`default_nettype none
`include "boot_strap_map.svh"

module boot_source_strap_decoder (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic boot_select_bit0_n_i,
    input wire logic boot_select_bit1_n_i,
    input wire logic boot_select_bit2_n_i,
    input wire logic spi_port1_select0_strap_i,
    input wire logic spi_port0_select1_strap_i,
    input wire logic spi_port1_clock_strap_i,
    input wire logic uart0_txd_strap_i,
    input wire logic uart0_rts_strap_i,
    input wire logic uart2_txd_strap_i,
    input wire logic uart2_rts_strap_i,
    input wire logic spi_port1_dout_strap_i,
    output logic strap_pins_input_o,
    output logic [2:0] boot_source_o,
    output logic carrier_spi_fetch_o,
    output logic module_spi_fetch_o,
    output logic [`STRAP_WIDTH-1:0] config_straps_o,
    output logic selection_valid_o
);

    ////////////////////////////////////////////////////////////////////////
    // Decode helper

    // Carrier firmware only for the carrier SPI code; every other code,
    // including the ones that name carrier media, falls back to the
    // on-module SPI flash
    function automatic logic is_carrier_spi(input logic [2:0] code);
        is_carrier_spi = (code == `BOOT_CODE_CARRIER_SPI);
    endfunction : is_carrier_spi

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    // Selects and straps come from the board, outside the clock domain,
    // so each passes two flip-flops before the sequencer reads it. The
    // selects reset to their pulled-up level so the held code never
    // shows a carrier source before capture.

    logic [2:0] select_pins; // Raw select levels, high means floating
    logic [2:0] select_sync; // Synchronised selects
    logic [`STRAP_WIDTH-1:0] strap_pins; // Raw strap levels
    logic [`STRAP_WIDTH-1:0] strap_sync; // Synchronised straps

    // Selects arrive active low; pulled-up floating reads high
    assign select_pins = {boot_select_bit2_n_i, boot_select_bit1_n_i,
                          boot_select_bit0_n_i};

    // Gather straps into their positions
    always_comb begin
        strap_pins = `STRAP_RESET;
        strap_pins[`STRAP_SPI_PORT1_SELECT0_STRAP] = spi_port1_select0_strap_i;
        strap_pins[`STRAP_SPI_PORT0_SELECT1_STRAP] = spi_port0_select1_strap_i;
        strap_pins[`STRAP_SPI_PORT1_CLOCK_STRAP] = spi_port1_clock_strap_i;
        strap_pins[`STRAP_UART0_TXD] = uart0_txd_strap_i;
        strap_pins[`STRAP_UART0_RTS] = uart0_rts_strap_i;
        strap_pins[`STRAP_UART2_TXD] = uart2_txd_strap_i;
        strap_pins[`STRAP_UART2_RTS] = uart2_rts_strap_i;
        strap_pins[`STRAP_SPI1_DOUT] = spi_port1_dout_strap_i;
    end

    // Select pins idle high through module pull-ups
    pin_sync #(
        .WIDTH(3),
        .RESET_VALUE({3{`SYNC_RESET_HIGH}})
    ) select_sync_inst (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .pin_i(select_pins),
        .sync_o(select_sync)
    );

    // Strap pins, read while their drivers are off
    pin_sync #(
        .WIDTH(`STRAP_WIDTH),
        .RESET_VALUE(`STRAP_RESET)
    ) strap_sync_inst (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .pin_i(strap_pins),
        .sync_o(strap_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // Capture sequencer

    // Leaving reset the sequencer spends two edges letting both
    // synchronisers fill with levels taken after release, captures on
    // the third edge and then holds everything until the next reset.
    // Pin levels seen while reset is still asserted are never used: the
    // synchronisers sit in reset then, so the carrier must keep its
    // grounds and floats steady from release through the capture edge.
    // Later pin changes are ignored without any indication.

    // Sequencer position
    boot_strap_pkg::capture_state_t state; // Sequencer state
    boot_strap_pkg::capture_state_t next_state; // Next sequencer state
    logic [1:0] settle; // Settle edges after the first edge since release
    logic [1:0] next_settle; // Next settle count

    // Held selection
    logic [2:0] code; // Held select code
    logic [2:0] next_code; // Next held code
    logic [`STRAP_WIDTH-1:0] straps; // Held strap values
    logic [`STRAP_WIDTH-1:0] next_straps; // Next held straps

    // Pin direction and fetch decisions
    logic pins_input; // Strap pins released as inputs
    logic next_pins_input; // Next release flag
    logic carrier_fetch; // Carrier SPI chosen
    logic next_carrier_fetch; // Next carrier choice
    logic module_fetch; // On-module SPI flash chosen
    logic next_module_fetch; // Next module choice
    logic valid; // Selection captured
    logic next_valid; // Next captured flag

    // Wait for synchronisers to fill with post-reset levels, then hold
    always_comb begin
        // Everything keeps its value unless a branch says otherwise
        next_state = state;
        next_settle = settle;
        next_code = code;
        next_straps = straps;
        next_pins_input = pins_input;
        next_carrier_fetch = carrier_fetch;
        next_module_fetch = module_fetch;
        next_valid = valid;
        case (state)
            boot_strap_pkg::ST_RESET: begin
                // First edge after release: sampling window opens
                next_state = boot_strap_pkg::ST_SETTLE;
                next_settle = `SETTLE_START;
            end
            boot_strap_pkg::ST_SETTLE: begin
                // Two edges fill the synchroniser
                if (settle == `SETTLE_LAST) begin
                    // Capture edge: take code and straps together
                    next_state = boot_strap_pkg::ST_HELD;
                    next_code = select_sync;
                    next_straps = strap_sync;
                    // Exactly one of the two fetch paths is chosen
                    next_carrier_fetch = is_carrier_spi(select_sync);
                    next_module_fetch = ~is_carrier_spi(select_sync);
                    next_valid = 1'h1;
                    next_pins_input = 1'h0; // Straps taken; pins may drive
                end else begin
                    // Still filling
                    next_settle = settle + `SETTLE_STEP;
                end
            end
            boot_strap_pkg::ST_HELD: begin
                // Ignore later pin changes until reset
                next_state = boot_strap_pkg::ST_HELD;
            end
            default: begin
                // Unused encoding: restart the capture
                next_state = boot_strap_pkg::ST_RESET;
            end
        endcase
    end

    // Register sequencer state; reset holds straps as inputs
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            // Nothing captured, module SPI code, pins kept as inputs
            state <= boot_strap_pkg::ST_RESET;
            settle <= `SETTLE_START;
            code <= `BOOT_CODE_RESET;
            straps <= `STRAP_RESET;
            pins_input <= 1'h1;
            carrier_fetch <= 1'h0;
            module_fetch <= 1'h0;
            valid <= 1'h0;
        end else begin
            // Normal running: take the next values
            state <= next_state;
            settle <= next_settle;
            code <= next_code;
            straps <= next_straps;
            pins_input <= next_pins_input;
            carrier_fetch <= next_carrier_fetch;
            module_fetch <= next_module_fetch;
            valid <= next_valid;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, straight from flip-flops

    // Every output is a plain register, so the pin direction and the
    // fetch choice never glitch while the decode above settles.

    // Pin direction
    assign strap_pins_input_o = pins_input;
    // Held boot source code
    assign boot_source_o = code;
    // Carrier SPI device chosen
    assign carrier_spi_fetch_o = carrier_fetch;
    // On-module SPI flash chosen
    assign module_spi_fetch_o = module_fetch;
    // Held configuration straps
    assign config_straps_o = straps;
    // Capture has happened
    assign selection_valid_o = valid;

endmodule : boot_source_strap_decoder

`default_nettype wire

//--- verif/carrier_strap_model.sv
// Carrier side wiring of the boot selects and strap pins
`timescale 1ns/1ns
`default_nettype none
module carrier_strap_model (
    input wire logic [2:0] ground_en_i,
    input wire logic [7:0] strap_pull_i,
    output logic [2:0] select_n_o,
    output logic [7:0] strap_o
);
    // Open drain grounds a select, else the module pull-up wins
    assign select_n_o = ~ground_en_i;
    // No carrier load, so the internal pulls alone set each strap
    assign strap_o = strap_pull_i;
endmodule : carrier_strap_model
`default_nettype wire

//--- verif/boot_strap_checker_sva.sv
// Assertions on the boot source strap decoder ports
`timescale 1ns/1ns
`default_nettype none
module boot_strap_checker (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic boot_select_bit0_n_i,
    input wire logic boot_select_bit1_n_i,
    input wire logic boot_select_bit2_n_i,
    input wire logic spi_port1_select0_strap_i,
    input wire logic spi_port0_select1_strap_i,
    input wire logic spi_port1_clock_strap_i,
    input wire logic uart0_txd_strap_i,
    input wire logic uart0_rts_strap_i,
    input wire logic uart2_txd_strap_i,
    input wire logic uart2_rts_strap_i,
    input wire logic spi_port1_dout_strap_i,
    input wire logic strap_pins_input_o,
    input wire logic [2:0] boot_source_o,
    input wire logic carrier_spi_fetch_o,
    input wire logic module_spi_fetch_o,
    input wire logic [7:0] config_straps_o,
    input wire logic selection_valid_o
);
    logic [1:0] cnt; // Edges since release, stops at three
    logic [1:0] next_cnt; // Next edge count
    // Count up to the capture edge
    always_comb next_cnt = (cnt == 2'h3) ? cnt : cnt + 2'h1;
    // Register the count, cleared by reset
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) cnt <= 2'h0;
        else cnt <= next_cnt;
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////
    a_fetch_carrier: assert property (
        carrier_spi_fetch_o == (selection_valid_o && boot_source_o == 3'h3))
        else $error("carrier fetch flag wrong");
    a_fetch_module: assert property (
        module_spi_fetch_o == (selection_valid_o && boot_source_o != 3'h3))
        else $error("module fetch flag wrong");
    a_strap_dir: assert property (strap_pins_input_o == !selection_valid_o)
        else $error("strap direction wrong");
    a_hold_stable: assert property (selection_valid_o |=> selection_valid_o
        && $stable(boot_source_o) && $stable(config_straps_o)) else $error("capture moved");
    a_valid_time: assert property (selection_valid_o == (cnt == 2'h3))
        else $error("capture edge wrong");
    a_decode_code: assert property ($rose(selection_valid_o) |-> boot_source_o ==
        {$past(boot_select_bit2_n_i, 3), $past(boot_select_bit1_n_i, 3),
        $past(boot_select_bit0_n_i, 3)}) else $error("boot code wrong");
    a_strap_take: assert property ($rose(selection_valid_o) |-> config_straps_o ==
        {$past(spi_port1_dout_strap_i, 3), $past(uart2_rts_strap_i, 3),
        $past(uart2_txd_strap_i, 3), $past(uart0_rts_strap_i, 3), $past(uart0_txd_strap_i, 3),
        $past(spi_port1_clock_strap_i, 3), $past(spi_port0_select1_strap_i, 3),
        $past(spi_port1_select0_strap_i, 3)}) else $error("straps wrong");
endmodule : boot_strap_checker
bind boot_source_strap_decoder boot_strap_checker i_checker (.clock_i, .rst_i,
    .boot_select_bit0_n_i, .boot_select_bit1_n_i, .boot_select_bit2_n_i,
    .spi_port1_select0_strap_i, .spi_port0_select1_strap_i, .spi_port1_clock_strap_i,
    .uart0_txd_strap_i, .uart0_rts_strap_i, .uart2_txd_strap_i, .uart2_rts_strap_i,
    .spi_port1_dout_strap_i, .strap_pins_input_o, .boot_source_o, .carrier_spi_fetch_o,
    .module_spi_fetch_o, .config_straps_o, .selection_valid_o);
`default_nettype wire

//--- verif/boot_source_strap_decoder_bench.sv
// Bench for the boot source strap decoder
`timescale 1ns/1ns
`default_nettype none
module boot_source_strap_decoder_bench;
    logic clock_i, rst_i, strap_pins_input_o, carrier_spi_fetch_o, module_spi_fetch_o;
    logic selection_valid_o; // Capture done
    logic [2:0] boot_source_o, sel_n, gnd_en; // Code, select pins, carrier grounds
    logic [7:0] config_straps_o, straps, pull; // Held straps, strap pins, pulls
    int num_errors, checks, k, seed;
    carrier_strap_model i_carrier (.ground_en_i(gnd_en), .strap_pull_i(pull),
        .select_n_o(sel_n), .strap_o(straps));
    boot_source_strap_decoder i_dut (.clock_i, .rst_i, .boot_select_bit0_n_i(sel_n[0]),
        .boot_select_bit1_n_i(sel_n[1]), .boot_select_bit2_n_i(sel_n[2]),
        .spi_port1_select0_strap_i(straps[0]), .spi_port0_select1_strap_i(straps[1]),
        .spi_port1_clock_strap_i(straps[2]), .uart0_txd_strap_i(straps[3]),
        .uart0_rts_strap_i(straps[4]), .uart2_txd_strap_i(straps[5]),
        .uart2_rts_strap_i(straps[6]), .spi_port1_dout_strap_i(straps[7]),
        .strap_pins_input_o, .boot_source_o, .carrier_spi_fetch_o, .module_spi_fetch_o,
        .config_straps_o, .selection_valid_o);
    // Grounded select reads low, floating reads high
    function automatic logic [7:0] exp_code(input logic [2:0] g);
        return {5'h0, ~g};
    endfunction : exp_code
    task check_vec(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : check_vec
    task stop_test;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    // One reset, capture, then pin churn that must be ignored
    task run_boot(input logic [2:0] g, input logic [7:0] p);
        int w;
        @(posedge clock_i) rst_i <= 1'b1;
        gnd_en <= g;
        pull <= p;
        repeat (8) @(posedge clock_i);
        #1 check_vec({7'h0, strap_pins_input_o}, 8'h01);
        check_vec({5'h0, selection_valid_o, carrier_spi_fetch_o, module_spi_fetch_o}, 8'h00);
        check_vec({5'h0, boot_source_o}, 8'h07);
        @(posedge clock_i) rst_i <= 1'b0;
        w = 0;
        while (selection_valid_o !== 1'b1) begin
            @(posedge clock_i) #1 w++;
            if (w > 10) begin
                num_errors++;
                stop_test();
            end
        end
        check_vec(8'(w), 8'h03);
        check_vec({5'h0, boot_source_o}, exp_code(g));
        check_vec({7'h0, carrier_spi_fetch_o}, {7'h0, exp_code(g) == 8'h03});
        check_vec({7'h0, module_spi_fetch_o}, {7'h0, exp_code(g) != 8'h03});
        check_vec({config_straps_o}, p);
        check_vec({7'h0, strap_pins_input_o}, 8'h00);
        @(posedge clock_i) gnd_en <= 3'($urandom);
        pull <= 8'($urandom);
        repeat (4) @(posedge clock_i);
        #1 check_vec({5'h0, boot_source_o}, exp_code(g));
        check_vec(config_straps_o, p);
        check_vec({7'h0, carrier_spi_fetch_o}, {7'h0, exp_code(g) == 8'h03});
        check_vec({7'h0, module_spi_fetch_o}, {7'h0, exp_code(g) != 8'h03});
    endtask : run_boot
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    initial begin
        {rst_i, gnd_en, pull, num_errors, checks} = {1'b1, 11'h0, 64'h0};
        seed = $urandom(32'hb85d483e);
        repeat (8) @(posedge clock_i);
        // Every code once, straps all-low for even codes and all-high for odd, then random
        for (k = 0; k < 8; k++) run_boot(3'(k), {8{k[0]}});
        for (k = 0; k < 16; k++) run_boot(3'($urandom), 8'($urandom));
        stop_test();
    end
endmodule : boot_source_strap_decoder_bench
`default_nettype wire
